//--- rtl/host_address_decode_regmap.sv
// Host address decoder and I/O register map of the network controller
`timescale 1ns/10ps
// What this block does
// RULE1 - Compare host address with strap ranges to find PROM, RAM or I/O target.
// RULE2 - I/O straps pick one of eight 16-location windows 0260h to 03E0h.
// RULE3 - Memory straps expand to nine bits matched against A19-A11.
// RULE4 - Upper 8K of the selected 16K segment is PROM, A13 high.
// RULE5 - RAM is one 2K area of lower 8K, A13 low, chosen by A12-A11.
// RULE6 - PROM uses seven-bit strap expansion matched against A19-A13.
// RULE7 - In I/O-mapped 16K mode the PROM decodes a single 16K range.
// RULE8 - Decode-disable high drops PROM select, upper lane and ready.
// RULE9 - I/O straps expand to twelve bits matched against A15-A4.
// RULE10 - I/O decoding only while AEN is low.
// RULE11 - Low four bits give read and write maps; 08-0B reset, 0C-0F data.
// RULE12 - Host never touches reserved offsets.
// RULE13 - Undefined bits read undefined; host writes them as zero.
// RULE14 - Status is read-only; writes at its offset reach the mask.
// RULE15 - Status resets to 1XX1 0001 on hardware or software reset.
// RULE16 - Status bit meanings differ while chained commands run.
// RULE17 - Out-of-range accesses get no select, data drive or ready change.
module host_address_decode_regmap (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [19:0] hostAddr,
  input wire logic aen,
  input wire logic memRead_n,
  input wire logic memWrite_n,
  input wire logic ioRead_n,
  input wire logic ioWrite_n,
  input wire logic [7:0] hostDataIn,
  input wire logic [4:0] memoryRangeStraps,
  input wire logic [2:0] ioRangeStraps,
  input wire logic prom_decode_disable_n,
  input wire logic io16kMode,
  input wire logic [7:0] statusNormal,
  input wire logic [7:0] statusChained,
  input wire logic [7:0] diagFlags,
  input wire logic [15:0] bufferReadWord,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic ramSelect,
  output logic boot_rom_select_n,
  output logic upper_lane_select_n,
  output logic ioChannelReadyOe,
  output logic softReset,
  output logic commandStrobe,
  output logic [7:0] commandByte,
  output logic [7:0] interruptMask,
  output logic [7:0] configuration,
  output logic [7:0] station_number_bits,
  output logic [7:0] externalLatch,
  output logic [10:0] bufferPointer,
  output logic [7:0] bufferWriteData,
  output logic bufferWriteLow,
  output logic bufferWriteHigh,
  output logic bufferReadLow
);
  logic [2:0] ioSync1;
  logic [2:0] ioSync2;
  logic [2:0] ioSync3;
  logic [4:0] memSync1;
  logic [4:0] memSync2;
  logic [4:0] memSync3;
  logic romSync1;
  logic romSync2;
  logic romSync3;
  logic [2:0] ioStrap_reg;
  logic [4:0] memStrap_reg;
  logic romDisable_reg;
  logic [8:0] memMatch;
  logic [6:0] promMatch;
  logic [11:0] ioMatch;
  logic memCycle;
  logic segHit;
  logic promHit;
  logic ioHit;
  logic [3:0] ioOffset;
  logic ioRd;
  logic ioWr;
  logic [7:0] readMux;
  logic [7:0] status_reg;
  logic anyReset;
  logic resetPulse;
  logic autoIncrement_reg;

  // Write hit on one offset; shared by the strobe, pointer and data paths
  function automatic logic writeAt(input logic wr, input logic [3:0] ofs,
                                   input logic [3:0] target);
    writeAt = wr && ofs == target;
  endfunction : writeAt

  // Strap pins are asynchronous; accept a change once stages 2 and 3 agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ioSync1 <= 3'h0;
      ioSync2 <= 3'h0;
      ioSync3 <= 3'h0;
      memSync1 <= 5'h00;
      memSync2 <= 5'h00;
      memSync3 <= 5'h00;
      // Reset to the disabled level so no PROM decode flickers after reset
      romSync1 <= 1'b1;
      romSync2 <= 1'b1;
      romSync3 <= 1'b1;
    end else begin
      ioSync1 <= ioRangeStraps;
      ioSync2 <= ioSync1;
      ioSync3 <= ioSync2;
      memSync1 <= memoryRangeStraps;
      memSync2 <= memSync1;
      memSync3 <= memSync2;
      romSync1 <= prom_decode_disable_n;
      romSync2 <= romSync1;
      romSync3 <= romSync2;
    end
  end

  // Filtered strap values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ioStrap_reg <= 3'h0;
      memStrap_reg <= 5'h00;
      romDisable_reg <= 1'b1;
    end else begin
      if (ioSync2 == ioSync3) ioStrap_reg <= ioSync3;
      if (memSync2 == memSync3) memStrap_reg <= memSync3;
      if (romSync2 == romSync3) romDisable_reg <= romSync3;
    end
  end

  strap_range_decode u_decode (
    .memoryRangeStraps(memStrap_reg),
    .ioRangeStraps(ioStrap_reg),
    .memMatch(memMatch),
    .promMatch(promMatch),
    .ioMatch(ioMatch)
  );

  // Memory and PROM window hits
  assign memCycle = !memRead_n || !memWrite_n;
  assign segHit = memCycle && (hostAddr[19:11] == memMatch); // [RULE1] [RULE3]
  always_comb begin
    promHit = 1'b0;
    if (memCycle && !romDisable_reg) begin // [RULE8]
      if (io16kMode) begin
        promHit = hostAddr[19:14] == promMatch[6:1]; // [RULE7]
      end else begin
        promHit = hostAddr[19:13] == promMatch && hostAddr[13]; // [RULE4] [RULE6]
      end
    end
  end
  assign ramSelect = segHit && !hostAddr[13]; // [RULE5] [RULE17]
  assign boot_rom_select_n = !promHit; // [RULE8] [RULE17]
  assign upper_lane_select_n = !(promHit && configuration[7]);
  assign ioChannelReadyOe = promHit;

  // I/O window hit, gated by AEN low
  assign ioHit = !aen && (hostAddr[15:4] == ioMatch); // [RULE9] [RULE10]
  assign ioOffset = hostAddr[3:0];
  assign ioRd = ioHit && !ioRead_n;
  assign ioWr = ioHit && !ioWrite_n;

  reset_port_detect u_reset (
    .mclk(mclk),
    .rst_n(rst_n),
    .ioHit(ioHit),
    .ioOffset(ioOffset),
    .strobe(!ioRead_n || !ioWrite_n),
    .softReset(resetPulse)
  );
  assign softReset = resetPulse;
  assign anyReset = resetPulse;

  // Write-side registers; undefined bits stored as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interruptMask <= host_decode_pkg::MASK_RESET;
      configuration <= host_decode_pkg::CONFIG_RESET;
      station_number_bits <= host_decode_pkg::STATION_RESET;
      externalLatch <= host_decode_pkg::LATCH_RESET;
    end else if (anyReset) begin
      interruptMask <= host_decode_pkg::MASK_RESET;
    end else if (ioWr) begin
      unique case (ioOffset)
        host_decode_pkg::OFS_STATUS:
          interruptMask <= hostDataIn & host_decode_pkg::MASK_WRITABLE; // [RULE14] [RULE13]
        host_decode_pkg::OFS_CONFIG: configuration <= hostDataIn;
        host_decode_pkg::OFS_STATION: station_number_bits <= hostDataIn;
        host_decode_pkg::OFS_EXTLATCH: externalLatch <= hostDataIn;
        default: ;
      endcase
    end
  end

  // Command strobe, one cycle per clock edge the write is held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      commandStrobe <= 1'b0;
      commandByte <= 8'h00;
    end else begin
      commandStrobe <= writeAt(ioWr, ioOffset, host_decode_pkg::OFS_DIAG); // [RULE11]
      if (writeAt(ioWr, ioOffset, host_decode_pkg::OFS_DIAG)) commandByte <= hostDataIn;
    end
  end

  // Buffer pointer loaded by host writes to the pointer ports; no auto-increment on data port access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bufferPointer <= host_decode_pkg::PTR_RESET;
    end else if (writeAt(ioWr, ioOffset, host_decode_pkg::OFS_PTR_LOW)) begin
      bufferPointer[7:0] <= hostDataIn;
    end else if (writeAt(ioWr, ioOffset, host_decode_pkg::OFS_PTR_HIGH)) begin
      bufferPointer[10:8] <= hostDataIn[2:0];
    end
  end

  // Auto-increment bit is only stored and read back; stepping is left to the core
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      autoIncrement_reg <= 1'b0;
    end else if (writeAt(ioWr, ioOffset, host_decode_pkg::OFS_PTR_HIGH)) begin
      autoIncrement_reg <= hostDataIn[host_decode_pkg::PTR_AUTOINC_BIT];
    end
  end

  // Data port strobes to the buffer RAM
  assign bufferWriteData = hostDataIn;
  assign bufferWriteLow = writeAt(ioWr, ioOffset, host_decode_pkg::OFS_DATA_LOW); // [RULE11]
  assign bufferWriteHigh = writeAt(ioWr, ioOffset, host_decode_pkg::OFS_DATA_HIGH);
  assign bufferReadLow = ioRd && ioOffset == host_decode_pkg::OFS_DATA_LOW;

  // Status: reset value on either reset, then live from core
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= host_decode_pkg::STATUS_RESET; // [RULE15]
    end else if (anyReset) begin
      status_reg <= host_decode_pkg::STATUS_RESET; // [RULE15]
    end else if (configuration[host_decode_pkg::CFG_CHAIN_BIT]) begin
      status_reg <= statusChained; // [RULE16]
    end else begin
      status_reg <= statusNormal;
    end
  end

  // Read map; reserved offsets read zero
  always_comb begin
    readMux = 8'h00;
    unique case (ioOffset)
      host_decode_pkg::OFS_STATUS: readMux = status_reg; // [RULE14]
      host_decode_pkg::OFS_DIAG: readMux = diagFlags;
      host_decode_pkg::OFS_CONFIG: readMux = configuration;
      host_decode_pkg::OFS_IOSTRAP: readMux = {5'h00, ioStrap_reg};
      host_decode_pkg::OFS_MEMSTRAP: readMux = {3'h0, memStrap_reg};
      host_decode_pkg::OFS_STATION: readMux = station_number_bits;
      host_decode_pkg::OFS_DATA_LOW: readMux = bufferReadWord[7:0];
      host_decode_pkg::OFS_DATA_HIGH: readMux = bufferReadWord[15:8];
      host_decode_pkg::OFS_PTR_LOW: readMux = bufferPointer[7:0];
      host_decode_pkg::OFS_PTR_HIGH: readMux = {1'b0, autoIncrement_reg, 3'h0, bufferPointer[10:8]};
      default: readMux = 8'h00;
    endcase
  end

  // Registered read data; drive only on an I/O read hit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut <= 8'h00;
    end else begin
      hostDataOut <= readMux;
    end
  end
  assign hostDataOe = ioRd; // [RULE17] [RULE10]

  // Checks
  a_io_aen_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    aen |-> !hostDataOe && !bufferWriteLow) else $error("I/O decode while AEN high"); // [RULE10]
  a_prom_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    romDisable_reg |-> boot_rom_select_n && upper_lane_select_n && !ioChannelReadyOe)
    else $error("PROM select while disabled"); // [RULE8]
  a_ram_half: assert property (@(posedge mclk) disable iff (!rst_n)
    ramSelect |-> !hostAddr[13] && hostAddr[19:11] == memMatch)
    else $error("RAM select outside window"); // [RULE5]
  a_prom_upper: assert property (@(posedge mclk) disable iff (!rst_n)
    (!boot_rom_select_n && !io16kMode) |-> hostAddr[13]) else $error("PROM in lower half"); // [RULE4]
  a_status_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    resetPulse |=> status_reg == 8'h91) else $error("Status reset value wrong"); // [RULE15]
  a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (ioWr && ioOffset == 4'h0 && !resetPulse) |=> interruptMask == ($past(hostDataIn) & 8'h85))
    else $error("Mask write lost"); // [RULE14]
  a_chain_view: assert property (@(posedge mclk) disable iff (!rst_n)
    (configuration[6] && !resetPulse) |=> status_reg == $past(statusChained))
    else $error("Chained status not shown"); // [RULE16]
  a_io_window: assert property (@(posedge mclk) disable iff (!rst_n)
    hostDataOe |-> hostAddr[15:4] == ioMatch) else $error("Drive outside window"); // [RULE9]
  a_reset_port: assert property (@(posedge mclk) disable iff (!rst_n)
    (ioWr && ioOffset == 4'h9) |=> softReset) else $error("Reset port missed"); // [RULE11]

  // Selects stay quiet without a bus cycle; register and data-port writes land at their offsets
  a_idle_no_select: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
    !memCycle |-> !ramSelect && boot_rom_select_n && !ioChannelReadyOe)
    else $error("Select without memory cycle");
  a_oe_needs_read: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
    hostDataOe |-> !ioRead_n && !aen) else $error("Data drive without read");
  a_cmd_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    (ioWr && ioOffset == 4'h1) |=> commandStrobe && commandByte == $past(hostDataIn))
    else $error("Command write lost");
  a_station_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    (ioWr && ioOffset == 4'h5 && !resetPulse) |=> station_number_bits == $past(hostDataIn))
    else $error("Station write lost");
  a_data_low_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    bufferWriteLow |-> ioWr && ioOffset == 4'hc) else $error("Low data strobe misplaced");
  a_data_high_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    bufferWriteHigh |-> ioWr && ioOffset == 4'hd) else $error("High data strobe misplaced");
  a_ptr_low_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    (ioWr && ioOffset == 4'he) |=> bufferPointer[7:0] == $past(hostDataIn))
    else $error("Pointer low write lost");

  // PROM range follows the mode
  a_prom_16k_range: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
    (!boot_rom_select_n && io16kMode) |-> hostAddr[19:14] == promMatch[6:1])
    else $error("PROM select outside 16K range");
  a_prom_8k_range: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
    (!boot_rom_select_n && !io16kMode) |-> hostAddr[19:13] == promMatch)
    else $error("PROM select outside 8K range");
  a_ready_only_prom: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    ioChannelReadyOe |-> !boot_rom_select_n) else $error("Ready driven without PROM");

  // Status ignores writes; reserved writes change nothing
  a_status_ro: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
    (ioWr && ioOffset == 4'h0 && !resetPulse && !configuration[6])
    |=> status_reg == $past(statusNormal)) else $error("Status changed by write");
  a_reserved_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    (ioWr && ioOffset == 4'h6 && !resetPulse) |=> $stable(configuration) && $stable(interruptMask))
    else $error("Reserved write changed state");
endmodule : host_address_decode_regmap

//--- rtl/host_decode_pkg.sv
// Constants for the host address decoder and register map
package host_decode_pkg;
  // Register offsets within the 16-location I/O window
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_DIAG = 4'h1;
  localparam logic [3:0] OFS_CONFIG = 4'h2;
  localparam logic [3:0] OFS_IOSTRAP = 4'h3;
  localparam logic [3:0] OFS_MEMSTRAP = 4'h4;
  localparam logic [3:0] OFS_STATION = 4'h5;
  localparam logic [3:0] OFS_RSVD6 = 4'h6;
  localparam logic [3:0] OFS_EXTLATCH = 4'h7;
  localparam logic [3:0] OFS_RESET_FIRST = 4'h8;
  localparam logic [3:0] OFS_RESET_LAST = 4'hb;
  localparam logic [3:0] OFS_DATA_LOW = 4'hc;
  localparam logic [3:0] OFS_DATA_HIGH = 4'hd;
  localparam logic [3:0] OFS_PTR_LOW = 4'he;
  localparam logic [3:0] OFS_PTR_HIGH = 4'hf;
  // Reset values; undefined status bits are driven as zero
  localparam logic [7:0] STATUS_RESET = 8'h91;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATION_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic [10:0] PTR_RESET = 11'h000;
  // Writable bit masks: undefined positions are stored as zero
  localparam logic [7:0] MASK_WRITABLE = 8'h85;
  localparam logic [7:0] PTR_HIGH_WRITABLE = 8'h47;
  // Field positions
  localparam int CFG_CHAIN_BIT = 6;
  localparam int PTR_AUTOINC_BIT = 6;
  localparam int STATUS_POR_BIT = 4;
  // Segment field widths on the host address bus
  localparam int MEM_MATCH_W = 9;
  localparam int PROM_MATCH_W = 7;
  localparam int IO_MATCH_W = 12;
endpackage : host_decode_pkg

//--- rtl/reset_port_detect.sv
// Soft reset request from host access to the reset locations
`timescale 1ns/10ps
module reset_port_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ioHit,
  input wire logic [3:0] ioOffset,
  input wire logic strobe,
  output logic softReset
);
  logic hitReset;
  // Either read or write of offsets 08-0B resets
  assign hitReset = ioHit && strobe && ioOffset >= host_decode_pkg::OFS_RESET_FIRST
                    && ioOffset <= host_decode_pkg::OFS_RESET_LAST; // [RULE11]
  // Registered so the reset lands cleanly after the access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      softReset <= 1'b0;
    end else begin
      softReset <= hitReset;
    end
  end
endmodule : reset_port_detect

//--- rtl/strap_range_decode.sv
// Strap-to-address expansion for memory and I/O windows
`timescale 1ns/10ps
module strap_range_decode (
  input wire logic [4:0] memoryRangeStraps,
  input wire logic [2:0] ioRangeStraps,
  output logic [8:0] memMatch,
  output logic [6:0] promMatch,
  output logic [11:0] ioMatch
);
  // 5-to-9 memory expansion: table steps in 16K blocks of C0000-E3FFF
  always_comb begin
    logic [6:0] seg;
    seg = 7'h00;
    // Codes 0-1 -> C0,C4; codes 2.. skip C8 (per table ordering)
    unique case (memoryRangeStraps[4:2])
      3'h0: seg = 7'h60;
      3'h1: seg = 7'h62;
      3'h2: seg = 7'h66;
      3'h3: seg = 7'h68;
      3'h4: seg = 7'h6a;
      3'h5: seg = 7'h6c;
      3'h6: seg = 7'h6e;
      3'h7: seg = 7'h70;
    endcase
    memMatch = {seg, memoryRangeStraps[1:0]}; // [RULE3] [RULE5]
    promMatch = {seg[6:1], 1'b1}; // [RULE6]
  end

  // 3-to-12 I/O expansion to A15-A4 [RULE2] [RULE9]
  always_comb begin
    unique case (ioRangeStraps)
      3'h0: ioMatch = 12'h026;
      3'h1: ioMatch = 12'h029;
      3'h2: ioMatch = 12'h02e;
      3'h3: ioMatch = 12'h02f;
      3'h4: ioMatch = 12'h030;
      3'h5: ioMatch = 12'h035;
      3'h6: ioMatch = 12'h038;
      3'h7: ioMatch = 12'h03e;
    endcase
  end
endmodule : strap_range_decode

//--- testbench/host_bus_model.sv
// Host processor model driving I/O and memory cycles on the expansion bus
`timescale 1ns/10ps
module host_bus_model (
  input wire logic mclk,
  input wire logic [7:0] hostDataOut,
  input wire logic ramSelect,
  input wire logic boot_rom_select_n,
  input wire logic ioChannelReadyOe,
  output logic [19:0] hostAddr,
  output logic aen,
  output logic memRead_n,
  output logic memWrite_n,
  output logic ioRead_n,
  output logic ioWrite_n,
  output logic [7:0] hostDataIn
);
  // Idle bus at time zero
  initial begin
    hostAddr = 20'h0_0000;
    aen = 1'b0;
    memRead_n = 1'b1;
    memWrite_n = 1'b1;
    ioRead_n = 1'b1;
    ioWrite_n = 1'b1;
    hostDataIn = 8'h00;
  end

  // One-edge I/O write; dma raises AEN to show a non-processor cycle
  task automatic io_write(input logic [15:0] a, input logic [7:0] d, input logic dma);
    @(posedge mclk);
    hostAddr <= {4'h0, a};
    aen <= dma;
    hostDataIn <= d;
    ioWrite_n <= 1'b0;
    @(posedge mclk);
    ioWrite_n <= 1'b1;
    aen <= 1'b0;
    hostDataIn <= ~d; // Released data lines do not keep the last value
    // Registers and pulse counters settle before the caller checks them
    @(posedge mclk);
    @(negedge mclk);
  endtask : io_write

  // Read data is registered, so the strobe is held over two edges
  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    hostAddr <= {4'h0, a};
    aen <= 1'b0;
    ioRead_n <= 1'b0;
    repeat (2) @(posedge mclk);
    d = hostDataOut;
    ioRead_n <= 1'b1;
  endtask : io_read

  // Memory read; selects are combinational and taken at the next edge
  task automatic mem_read(input logic [19:0] a, output logic [2:0] sel);
    @(posedge mclk);
    hostAddr <= a;
    memRead_n <= 1'b0;
    @(posedge mclk);
    sel = {ramSelect, boot_rom_select_n, ioChannelReadyOe};
    memRead_n <= 1'b1;
  endtask : mem_read
endmodule : host_bus_model

//--- testbench/tb.sv
// Self-checking bench for the host address decoder and register map
`timescale 1ns/10ps
module tb;
  logic mclk, rst_n, io16kMode, aen, memRead_n, memWrite_n, ioRead_n, ioWrite_n;
  logic prom_decode_disable_n, ramSelect, boot_rom_select_n, upper_lane_select_n;
  logic hostDataOe, ioChannelReadyOe, softReset, commandStrobe, bufferWriteLow;
  logic bufferWriteHigh, bufferReadLow;
  logic [19:0] hostAddr;
  logic [7:0] hostDataIn, hostDataOut, statusNormal, statusChained, diagFlags, commandByte;
  logic [7:0] interruptMask, configuration, station_number_bits, externalLatch, bufferWriteData;
  logic [4:0] memoryRangeStraps;
  logic [2:0] ioRangeStraps;
  logic [15:0] bufferReadWord;
  logic [10:0] bufferPointer;
  int errorCnt = 0;
  int comparisons = 0;
  int rstCnt = 0;
  int cmdCnt = 0;
  logic [15:0] ioBase [8] = '{16'h0260, 16'h0290, 16'h02E0, 16'h02F0, 16'h0300, 16'h0350,
                              16'h0380, 16'h03E0};

  host_address_decode_regmap u_host_address_decode_regmap (.*);
  host_bus_model u_host_bus_model (.*);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Pulse counters; a pulse stretched over two edges counts twice
  always @(posedge mclk) begin
    if (softReset === 1'b1) rstCnt++;
    if (commandStrobe === 1'b1) cmdCnt++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic closeOut();
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : closeOut

  // Every strap code opens its own window; DMA and neighbour windows miss
  task automatic t_io_windows();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      ioRangeStraps <= i[2:0];
      repeat (5) @(posedge mclk);
      u_host_bus_model.io_write(ioBase[i] + 16'h0005, 8'h10 + i[7:0], 1'b0);
      chk("station", 16'h0010 + i[15:0], {8'h00, station_number_bits});
      u_host_bus_model.io_write(ioBase[i] + 16'h0005, 8'hEE, 1'b1);
      chk("station dma", 16'h0010 + i[15:0], {8'h00, station_number_bits});
      u_host_bus_model.io_write(ioBase[i] + 16'h0015, 8'hDD, 1'b0);
      u_host_bus_model.io_read(ioBase[i] + 16'h0005, d);
      chk("station read", 16'h0010 + i[15:0], {8'h00, d});
    end
  endtask : t_io_windows

  // Register map behaviour within the last window; reserved offsets untouched
  task automatic t_regs();
    logic [7:0] d;
    u_host_bus_model.io_read(16'h03E0, d);
    chk("status reset", 16'h0091, {8'h00, d});
    u_host_bus_model.io_write(16'h03E0, 8'hFF, 1'b0);
    chk("mask", 16'h0085, {8'h00, interruptMask});
    u_host_bus_model.io_read(16'h03E0, d);
    chk("status ro", 16'h0091, {8'h00, d});
    u_host_bus_model.io_write(16'h03E1, 8'hA5, 1'b0);
    chk("cmd pulses", 16'h0001, cmdCnt[15:0]);
    chk("cmd byte", 16'h00A5, {8'h00, commandByte});
    u_host_bus_model.io_write(16'h03EE, 8'h34, 1'b0);
    u_host_bus_model.io_write(16'h03EF, 8'h07, 1'b0);
    chk("pointer", 16'h0734, {5'h00, bufferPointer});
    u_host_bus_model.io_write(16'h03E7, 8'h5C, 1'b0);
    chk("ext latch", 16'h005C, {8'h00, externalLatch});
    u_host_bus_model.io_read(16'h03EC, d);
    chk("data low", 16'h00A5, {8'h00, d});
    u_host_bus_model.io_read(16'h03ED, d);
    chk("data high", 16'h00C3, {8'h00, d});
    u_host_bus_model.io_write(16'h03E2, 8'h40, 1'b0);
    u_host_bus_model.io_read(16'h03E0, d);
    chk("status chained", 16'h005A, {8'h00, d});
    u_host_bus_model.io_write(16'h03E2, 8'h00, 1'b0);
    // Each reset location gives one pulse and clears the mask
    for (int k = 8; k < 12; k++) begin
      u_host_bus_model.io_write(16'h03E5, 8'h77, 1'b0);
      u_host_bus_model.io_write(16'h03E0, 8'h85, 1'b0);
      u_host_bus_model.io_write(16'h03E0 + k[15:0], 8'h00, 1'b0);
      repeat (2) @(posedge mclk);
      chk("soft reset pulses", k[15:0] - 16'd7, rstCnt[15:0]);
      chk("mask cleared", 16'h0000, {8'h00, interruptMask});
    end
  endtask : t_regs

  // Memory map for strap codes 00, 05 and 1F: RAM 2K area, PROM upper 8K, misses
  task automatic t_memory();
    logic [2:0] s;
    logic [44:0] tab [3] = '{{5'h00, 20'hC_0000, 20'hC_3FFF}, {5'h05, 20'hC_4800, 20'hC_6000},
                             {5'h1F, 20'hE_1800, 20'hE_2000}};
    foreach (tab[i]) begin
      memoryRangeStraps <= tab[i][44:40];
      prom_decode_disable_n <= 1'b0;
      repeat (5) @(posedge mclk);
      u_host_bus_model.mem_read(tab[i][39:20], s);
      chk("ram hit", 16'h0006, {13'h0, s});
      u_host_bus_model.mem_read(tab[i][39:20] ^ 20'h0_0800, s);
      chk("other 2k", 16'h0002, {13'h0, s});
      u_host_bus_model.mem_read(tab[i][19:0], s);
      chk("prom hit", 16'h0001, {13'h0, s});
      u_host_bus_model.mem_read(20'hA_0000, s);
      chk("no hit", 16'h0002, {13'h0, s});
      io16kMode <= 1'b1;
      u_host_bus_model.mem_read(tab[i][39:20], s);
      chk("prom 16k", 16'h0005, {13'h0, s});
      io16kMode <= 1'b0;
      prom_decode_disable_n <= 1'b1;
      repeat (5) @(posedge mclk);
      u_host_bus_model.mem_read(tab[i][19:0], s);
      chk("prom off", 16'h0002, {13'h0, s});
    end
  endtask : t_memory

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    closeOut();
  end

  initial begin
    rst_n = 1'b0;
    io16kMode = 1'b0;
    memoryRangeStraps = 5'h00;
    ioRangeStraps = 3'h0;
    prom_decode_disable_n = 1'b0;
    statusNormal = 8'h91;
    statusChained = 8'h5A;
    diagFlags = 8'h00;
    bufferReadWord = 16'hC3A5;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_io_windows();
    t_regs();
    t_memory();
    closeOut();
  end
endmodule : tb
